//--- design/cpm_consts.svh
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH

// register byte offsets
`define CPM_ADDR_CLK_MODE 8'h00
`define CPM_ADDR_SYS_CTRL 8'h04
`define CPM_ADDR_VTHR 8'h08
`define CPM_ADDR_STATUS 8'h0C

// clock_mode_register fields
`define CPM_CM_DIV_HI 7
`define CPM_CM_DIV_LO 5
`define CPM_CM_LOW_RDY 3
`define CPM_CM_HIGH_RDY 2
`define CPM_CM_IDLE_SEL 1
`define CPM_CM_HL_SEL 0
`define CPM_CM_DIV_RESET 3'h6
`define CPM_CM_IDLE_RESET 1'h1
`define CPM_CM_HL_RESET 1'h0

// system_control_register fields
`define CPM_SC_KEEP 7
`define CPM_SC_LV_FLAG 2
`define CPM_SC_BT_FLAG 1
`define CPM_SC_WK_FLAG 0

// status register fields
`define CPM_ST_PD_FLAG 1
`define CPM_ST_WE_FLAG 0

// voltage threshold codes, the first is the reset value
`define CPM_VTHR_CODE0 8'h55
`define CPM_VTHR_CODE1 8'h33
`define CPM_VTHR_CODE2 8'h99
`define CPM_VTHR_CODE3 8'hAA

// slow clock divider codes below this select the slow oscillator
`define CPM_DIV_FAST_MIN 3'h2

// oscillator settling counts, in oscillator cycles
`define CPM_FAST_SETTLE 8'h0F
`define CPM_SLOW_SETTLE 8'h01

`endif

//--- design/cpm_pkg.sv
package cpm_pkg;

    typedef enum logic [1:0] {
        CPM_MODE_RUN,
        CPM_MODE_SLEEP,
        CPM_MODE_IDLE_OFF,
        CPM_MODE_IDLE_ON
    } cpm_mode_type;

    typedef struct packed {
        logic [7:0] cnt;
        logic ready;
    } cpm_settle_state_type;

    typedef struct packed {
        logic [5:0] cnt;
        logic sel_tick;
        logic div16_tick;
        logic div64_tick;
    } cpm_div_state_type;

    typedef struct packed {
        cpm_mode_type mode;
        logic fs1;
        logic fs2;
        logic fs3;
        logic ss1;
        logic ss2;
        logic ss3;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic [2:0] div_sel;
        logic idle_sel;
        logic hl_sel;
        logic keep;
        logic lv_f;
        logic bt_f;
        logic wk_f;
        logic pd_f;
        logic we_f;
        logic [7:0] vthr;
        logic thr_bad_d;
        logic soft_rst;
        logic wdt_clr;
        logic cpu_run;
        logic sys_on;
        logic sys_tick;
        logic tbc_tick;
        logic sub_tick;
        logic fast_en;
        logic slow_restart;
    } cpm_top_state_type;

endpackage

//--- design/cpm_osc_if.sv
`timescale 1ns/10ps
`default_nettype none

interface cpm_osc_if;
    logic run;
    logic restart;
    logic edge_pulse;
    logic ready;
    modport settle (input run, input restart, input edge_pulse, output ready);
    modport ctrl (output run, output restart, output edge_pulse, input ready);
endinterface

`default_nettype wire

//--- design/cpm_settle.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpm_consts.svh"

module cpm_settle
    import cpm_pkg::*;
#(
    parameter logic [7:0] CYCLES = `CPM_FAST_SETTLE
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hclken,
    cpm_osc_if.settle osc
);
    cpm_settle_state_type r;
    cpm_settle_state_type nx;

    // counts oscillator edges after start, ready once settled
    always_comb begin
        nx = r;
        if (!osc.run || osc.restart) begin
            nx.cnt = 8'h00;
            nx.ready = 1'b0;
        end else if (!r.ready && osc.edge_pulse) begin
            nx.cnt = r.cnt + 8'h01;
            if (r.cnt == CYCLES - 8'h01) begin
                nx.ready = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else if (hclken) begin
            r <= nx;
        end
    end

    assign osc.ready = r.ready;
endmodule

`default_nettype wire

//--- design/cpm_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpm_consts.svh"

module cpm_divider
    import cpm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hclken,
    input wire logic run,
    input wire logic edge_in,
    input wire logic [2:0] sel,
    output logic sel_tick,
    output logic div16_tick,
    output logic div64_tick
);
    cpm_div_state_type r;
    cpm_div_state_type nx;
    logic [5:0] div_t;

    // one tick per 2^(g+1) fast edges
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : gen_div
            assign div_t[g] = edge_in & (&r.cnt[g:0]);
        end
    endgenerate

    always_comb begin
        nx = r;
        nx.sel_tick = 1'b0;
        nx.div16_tick = 1'b0;
        nx.div64_tick = 1'b0;
        if (!run) begin
            nx.cnt = 6'h00;
        end else begin
            if (edge_in) begin
                nx.cnt = r.cnt + 6'h01;
            end
            nx.sel_tick = (sel >= `CPM_DIV_FAST_MIN) & div_t[3'h7 - sel];
            nx.div16_tick = div_t[3];
            nx.div64_tick = div_t[5];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else if (hclken) begin
            r <= nx;
        end
    end

    assign sel_tick = r.sel_tick;
    assign div16_tick = r.div16_tick;
    assign div64_tick = r.div64_tick;
endmodule

`default_nettype wire

//--- design/cpm_top.sv
// Contract
// - slow ready rises 1-2 cycles after start
// - fast ready low asleep, rises after 15-16
// - halt enters idle or sleep by idle_select
// - idle_clock_keep chooses clock-on or clock-off idle
// - high_low_clock_select picks fast or divided/slow
// - slow clock selection stops fast oscillator, dividers
// - low-voltage flag set by event, software clears
// - bad threshold code resets, sets sticky flag
// - bad watchdog key sets sticky flag
// - unimplemented control bits read zero
// - divider codes 000/001 mean slow mode
// - codes 010-111 or fast select mean normal
// - slow clock used only once slow ready
// - sleep stops system and time-base clocks
// - low-power entry keeps state, clears watchdog
// - low-power entry sets power-down, clears expired
// - clock-off idle keeps time-base and substitute
// - clock-on idle keeps all clocks, cpu halted
// - divider code selects fast/64 through fast/2
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "cpm_consts.svh"

module cpm_top
    import cpm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hclken,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic fast_osc_clk,
    input wire logic slow_osc_clk,
    input wire logic halt_instr,
    input wire logic wake_event,
    input wire logic clr_wdt_instr,
    input wire logic wdt_timeout,
    input wire logic lvr_event,
    input wire logic wdt_key_bad,
    output logic cpu_run,
    output logic sys_clk_on,
    output logic sys_clk_tick,
    output logic tbc_tick,
    output logic sub_tick,
    output logic timer_div16_tick,
    output logic timer_div64_tick,
    output logic fast_osc_en,
    output logic wdt_clear,
    output logic soft_reset_req
);
    cpm_top_state_type r;
    cpm_top_state_type nx;
    cpm_osc_if fast_if ();
    cpm_osc_if slow_if ();
    logic fast_edge;
    logic slow_edge;
    logic div_sel_tick;
    logic acc;

    function automatic logic slow_pick(input logic hl, input logic [2:0] dv);
        slow_pick = !hl && (dv < `CPM_DIV_FAST_MIN);
    endfunction

    function automatic logic thr_ok(input logic [7:0] code);
        thr_ok = (code == `CPM_VTHR_CODE0) || (code == `CPM_VTHR_CODE1) ||
                 (code == `CPM_VTHR_CODE2) || (code == `CPM_VTHR_CODE3);
    endfunction

    function automatic logic [31:0] reg_read(input cpm_top_state_type s,
                                             input logic [7:0] a,
                                             input logic lo_rdy,
                                             input logic hi_rdy);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            `CPM_ADDR_CLK_MODE: begin
                d[`CPM_CM_DIV_HI:`CPM_CM_DIV_LO] = s.div_sel;
                d[`CPM_CM_LOW_RDY] = lo_rdy;
                d[`CPM_CM_HIGH_RDY] = hi_rdy;
                d[`CPM_CM_IDLE_SEL] = s.idle_sel;
                d[`CPM_CM_HL_SEL] = s.hl_sel;
            end
            `CPM_ADDR_SYS_CTRL: begin
                d[`CPM_SC_KEEP] = s.keep;
                d[`CPM_SC_LV_FLAG] = s.lv_f;
                d[`CPM_SC_BT_FLAG] = s.bt_f;
                d[`CPM_SC_WK_FLAG] = s.wk_f;
            end
            `CPM_ADDR_VTHR: begin
                d[7:0] = s.vthr;
            end
            `CPM_ADDR_STATUS: begin
                d[`CPM_ST_PD_FLAG] = s.pd_f;
                d[`CPM_ST_WE_FLAG] = s.we_f;
            end
            default: begin
                d = 32'h0000_0000;
            end
        endcase
        reg_read = d;
    endfunction

    // oscillator edges after two-stage synchronisers
    assign fast_edge = r.fs2 & !r.fs3;
    assign slow_edge = r.ss2 & !r.ss3;
    assign acc = hsel & htrans[1] & hready;

    assign fast_if.run = r.fast_en;
    assign fast_if.restart = 1'b0;
    assign fast_if.edge_pulse = fast_edge;
    assign slow_if.run = 1'b1;
    assign slow_if.restart = r.slow_restart;
    assign slow_if.edge_pulse = slow_edge;

    cpm_settle #(
        .CYCLES(`CPM_FAST_SETTLE)
    ) u_fast_settle (
        .hclk(hclk),
        .hresetn(hresetn),
        .hclken(hclken),
        .osc(fast_if.settle)
    );

    cpm_settle #(
        .CYCLES(`CPM_SLOW_SETTLE)
    ) u_slow_settle (
        .hclk(hclk),
        .hresetn(hresetn),
        .hclken(hclken),
        .osc(slow_if.settle)
    );

    cpm_divider u_divider (
        .hclk(hclk),
        .hresetn(hresetn),
        .hclken(hclken),
        .run(r.fast_en & fast_if.ready),
        .edge_in(fast_edge),
        .sel(r.div_sel),
        .sel_tick(div_sel_tick),
        .div16_tick(timer_div16_tick),
        .div64_tick(timer_div64_tick)
    );

    always_comb begin
        nx = r;
        nx.fs1 = fast_osc_clk;
        nx.fs2 = r.fs1;
        nx.fs3 = r.fs2;
        nx.ss1 = slow_osc_clk;
        nx.ss2 = r.ss1;
        nx.ss3 = r.ss2;
        nx.hreadyout = 1'b1;
        nx.hresp = 1'b0;
        nx.soft_rst = 1'b0;
        nx.wdt_clr = 1'b0;
        nx.slow_restart = 1'b0;

        // bus write in data phase
        nx.dp_wr = acc & hwrite;
        nx.dp_addr = haddr[7:0];
        if (r.dp_wr) begin
            unique case (r.dp_addr)
                `CPM_ADDR_CLK_MODE: begin
                    nx.div_sel = hwdata[`CPM_CM_DIV_HI:`CPM_CM_DIV_LO];
                    nx.idle_sel = hwdata[`CPM_CM_IDLE_SEL];
                    nx.hl_sel = hwdata[`CPM_CM_HL_SEL];
                end
                `CPM_ADDR_SYS_CTRL: begin
                    nx.keep = hwdata[`CPM_SC_KEEP];
                    nx.lv_f = r.lv_f & hwdata[`CPM_SC_LV_FLAG];
                    nx.bt_f = r.bt_f & hwdata[`CPM_SC_BT_FLAG];
                    nx.wk_f = r.wk_f & hwdata[`CPM_SC_WK_FLAG];
                end
                `CPM_ADDR_VTHR: begin
                    nx.vthr = hwdata[7:0];
                end
                default: begin
                    nx.vthr = nx.vthr;
                end
            endcase
        end

        // sticky reset causes, the event wins over a clear
        if (lvr_event) begin
            nx.lv_f = 1'b1;
        end
        if (wdt_key_bad) begin
            nx.wk_f = 1'b1;
        end
        nx.thr_bad_d = !thr_ok(r.vthr);
        if (!thr_ok(r.vthr)) begin
            nx.bt_f = 1'b1;
            nx.soft_rst = !r.thr_bad_d;
        end

        // halt and wake sequencing
        unique case (r.mode)
            CPM_MODE_RUN: begin
                if (halt_instr) begin
                    if (!r.idle_sel) begin
                        nx.mode = CPM_MODE_SLEEP;
                    end else if (r.keep) begin
                        nx.mode = CPM_MODE_IDLE_ON;
                    end else begin
                        nx.mode = CPM_MODE_IDLE_OFF;
                    end
                    nx.wdt_clr = 1'b1;
                    nx.pd_f = 1'b1;
                    nx.we_f = 1'b0;
                end
            end
            CPM_MODE_SLEEP, CPM_MODE_IDLE_OFF, CPM_MODE_IDLE_ON: begin
                if (wake_event) begin
                    nx.mode = CPM_MODE_RUN;
                    nx.slow_restart = 1'b1;
                end
            end
        endcase
        if (clr_wdt_instr) begin
            nx.pd_f = 1'b0;
        end
        if (wdt_timeout) begin
            nx.we_f = 1'b1;
        end

        // clock gating per mode
        nx.cpu_run = (nx.mode == CPM_MODE_RUN);
        nx.sys_on = (nx.mode == CPM_MODE_RUN) ||
                    (nx.mode == CPM_MODE_IDLE_ON);
        nx.fast_en = !slow_pick(nx.hl_sel, nx.div_sel) && nx.sys_on;

        // system clock source selection
        if (!r.sys_on) begin
            nx.sys_tick = 1'b0;
        end else if (r.hl_sel) begin
            nx.sys_tick = fast_edge & fast_if.ready;
        end else if (slow_pick(r.hl_sel, r.div_sel)) begin
            nx.sys_tick = slow_edge & slow_if.ready;
        end else begin
            nx.sys_tick = div_sel_tick;
        end

        // time-base and substitute clocks
        nx.tbc_tick = slow_edge & slow_if.ready &
                      (r.mode != CPM_MODE_SLEEP);
        nx.sub_tick = slow_edge & slow_if.ready;

        // read data from post-write values
        if (acc && !hwrite) begin
            nx.hrdata = reg_read(nx, haddr[7:0], slow_if.ready, fast_if.ready);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.mode <= CPM_MODE_RUN;
            r.hreadyout <= 1'b1;
            r.div_sel <= `CPM_CM_DIV_RESET;
            r.idle_sel <= `CPM_CM_IDLE_RESET;
            r.hl_sel <= `CPM_CM_HL_RESET;
            r.vthr <= `CPM_VTHR_CODE0;
            r.cpu_run <= 1'b1;
            r.sys_on <= 1'b1;
        end else if (hclken) begin
            r <= nx;
        end
    end

    assign hreadyout = r.hreadyout;
    assign hresp = r.hresp;
    assign hrdata = r.hrdata;
    assign cpu_run = r.cpu_run;
    assign sys_clk_on = r.sys_on;
    assign sys_clk_tick = r.sys_tick;
    assign tbc_tick = r.tbc_tick;
    assign sub_tick = r.sub_tick;
    assign fast_osc_en = r.fast_en;
    assign wdt_clear = r.wdt_clr;
    assign soft_reset_req = r.soft_rst;
endmodule

`default_nettype wire

//--- verif/cpm_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module cpm_top_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hclken,
    input wire logic halt_instr,
    input wire logic wake_event,
    input wire logic cpu_run,
    input wire logic sys_clk_on,
    input wire logic sys_clk_tick,
    input wire logic timer_div16_tick,
    input wire logic timer_div64_tick,
    input wire logic fast_osc_en,
    input wire logic wdt_clear,
    input wire logic soft_reset_req
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_halt;
        halt_instr && cpu_run && hclken;
    endsequence
    sequence s_enter;
        !cpu_run && wdt_clear;
    endsequence
    sequence s_fast_off;
        !fast_osc_en [*8];
    endsequence

    property p_halt_enter;
        s_halt |=> s_enter;
    endproperty
    a_halt_enter: assert property (p_halt_enter) else $error("halt not taken");
    property p_low_hold;
        !cpu_run && !wake_event |=> !cpu_run;
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("left low power unwoken");
    property p_wdt_pulse;
        wdt_clear |=> !wdt_clear;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog clear too long");
    property p_wdt_cause;
        wdt_clear |-> $fell(cpu_run);
    endproperty
    a_wdt_cause: assert property (p_wdt_cause) else $error("watchdog clear without entry");
    property p_cpu_off;
        !sys_clk_on |-> !cpu_run;
    endproperty
    a_cpu_off: assert property (p_cpu_off) else $error("cpu runs without clock");
    property p_sys_gate;
        !sys_clk_on [*2] |-> !sys_clk_tick;
    endproperty
    a_sys_gate: assert property (p_sys_gate) else $error("system tick while stopped");
    property p_idle_on;
        !cpu_run && sys_clk_on && !wake_event |=> sys_clk_on;
    endproperty
    a_idle_on: assert property (p_idle_on) else $error("clock lost in idle");
    property p_timer_stop;
        s_fast_off |-> !timer_div16_tick && !timer_div64_tick;
    endproperty
    a_timer_stop: assert property (p_timer_stop) else $error("timer tick, fast off");
    property p_soft_pulse;
        soft_reset_req |=> !soft_reset_req;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset too long");
endmodule

bind cpm_top cpm_top_monitor u_mon (.hclk, .hresetn, .hclken, .halt_instr, .wake_event,
    .cpu_run, .sys_clk_on, .sys_clk_tick, .timer_div16_tick, .timer_div64_tick,
    .fast_osc_en, .wdt_clear, .soft_reset_req);

`default_nettype wire

//--- verif/cpm_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpm_consts.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module cpm_top_tb_top;
    logic hclk, hresetn, hsel, hwrite, fast_osc_clk, slow_osc_clk, slow_go;
    logic halt_instr, wake_event, clr_wdt_instr, wdt_timeout, lvr_event, wdt_key_bad;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata;
    logic [3:0] slow_cnt;
    wire logic hreadyout, hresp, cpu_run, sys_clk_on, sys_clk_tick, tbc_tick, sub_tick;
    wire logic d16, d64, fast_osc_en, wdt_clear, soft_reset_req;
    wire logic [31:0] hrdata;
    int miscompares = 0;
    int n_checks = 0;
    int n_tbc = 0;
    int n_sub = 0;
    int n_sys = 0;
    int n_soft = 0;
    localparam logic [5:0] EV_HALT = 6'h20;
    localparam logic [5:0] EV_WAKE = 6'h10;
    localparam logic [5:0] EV_CLR = 6'h08;
    localparam logic [5:0] EV_TMO = 6'h04;
    localparam logic [5:0] EV_LVR = 6'h02;
    localparam logic [5:0] EV_KEY = 6'h01;

    cpm_top DUT (.hclk(hclk), .hresetn(hresetn), .hclken(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fast_osc_clk(fast_osc_clk),
        .slow_osc_clk(slow_osc_clk), .halt_instr(halt_instr), .wake_event(wake_event),
        .clr_wdt_instr(clr_wdt_instr), .wdt_timeout(wdt_timeout), .lvr_event(lvr_event),
        .wdt_key_bad(wdt_key_bad), .cpu_run(cpu_run), .sys_clk_on(sys_clk_on),
        .sys_clk_tick(sys_clk_tick), .tbc_tick(tbc_tick), .sub_tick(sub_tick),
        .timer_div16_tick(d16), .timer_div64_tick(d64), .fast_osc_en(fast_osc_en),
        .wdt_clear(wdt_clear), .soft_reset_req(soft_reset_req));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // oscillator models and tick counters
    always @(posedge hclk) begin
        slow_cnt <= slow_go ? slow_cnt + 4'h1 : slow_cnt;
        slow_osc_clk <= slow_cnt[3];
        fast_osc_clk <= (fast_osc_en === 1'b1) ? ~fast_osc_clk : fast_osc_clk;
        n_tbc <= n_tbc + ((tbc_tick === 1'b1) ? 1 : 0);
        n_sub <= n_sub + ((sub_tick === 1'b1) ? 1 : 0);
        n_sys <= n_sys + ((sys_clk_tick === 1'b1) ? 1 : 0);
        n_soft <= n_soft + ((soft_reset_req === 1'b1) ? 1 : 0);
    end

    task automatic conclude;
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        r = hrdata;
        if (n >= 50) begin
            miscompares++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, {24'h0, d}, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask

    task automatic pulse(input logic [5:0] m);
        {halt_instr, wake_event, clr_wdt_instr, wdt_timeout, lvr_event, wdt_key_bad} <= m;
        @(posedge hclk);
        {halt_instr, wake_event, clr_wdt_instr, wdt_timeout, lvr_event, wdt_key_bad} <= 6'h00;
    endtask

    task automatic wait_rdy;
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            rd(`CPM_ADDR_CLK_MODE, r);
            n++;
        end while (r[3:2] !== 2'b11 && n < 60);
        `CHK("osc ready", 2'b11, r[3:2])
        if (r[3:2] !== 2'b11) begin
            conclude();
        end
    endtask

    task automatic t_reset;
        logic [31:0] r;
        rd(`CPM_ADDR_CLK_MODE, r);
        `CHK("clock mode", 32'hC2, r)
        rd(`CPM_ADDR_SYS_CTRL, r);
        `CHK("sys ctrl", 32'h0, r)
        rd(`CPM_ADDR_VTHR, r);
        `CHK("threshold", 32'h55, r)
        wr(`CPM_ADDR_CLK_MODE, 8'hCE);
        rd(`CPM_ADDR_CLK_MODE, r);
        `CHK("ready bits", 32'hC2, r)
        wr(8'h10, 8'hFF);
        rd(8'h10, r);
        `CHK("unmapped", 32'h0, r)
    endtask

    task automatic t_ready;
        logic [31:0] r;
        slow_go <= 1'b1;
        wait_rdy();
        wr(`CPM_ADDR_CLK_MODE, 8'hF3);
        rd(`CPM_ADDR_CLK_MODE, r);
        `CHK("clock mode", 32'hEF, r)
        `CHK("bit 4", 1'b0, r[4])
    endtask

    task automatic t_div;
        int s;
        for (int c = 0; c < 8; c++) begin
            wr(`CPM_ADDR_CLK_MODE, {c[2:0], 5'h02});
            repeat (3) @(posedge hclk);
            `CHK("fast enable", c >= 2, fast_osc_en)
            if (c >= 2) begin
                wait_rdy();
            end
            s = n_sys;
            repeat (256) @(posedge hclk);
            if (c < 2) begin
                `CHK("slow ticks", 16, n_sys - s)
            end else begin
                `CHK("divided ticks", 256 >> (9 - c), n_sys - s)
            end
        end
        wr(`CPM_ADDR_CLK_MODE, 8'h03);
        repeat (3) @(posedge hclk);
        `CHK("fast enable", 1'b1, fast_osc_en)
    endtask

    task automatic t_low(input logic idle, input logic keep);
        logic [31:0] r;
        int c_tbc, c_sub, c_sys;
        wr(`CPM_ADDR_SYS_CTRL, {keep, 7'h00});
        wr(`CPM_ADDR_CLK_MODE, {3'h6, 3'h0, idle, 1'b0});
        wait_rdy();
        pulse(EV_CLR);
        pulse(EV_TMO);
        rd(`CPM_ADDR_STATUS, r);
        `CHK("status", 32'h1, r)
        pulse(EV_HALT);
        @(posedge hclk);
        `CHK("cpu run", 1'b0, cpu_run)
        `CHK("sys clock on", idle & keep, sys_clk_on)
        `CHK("wdt clear", 1'b1, wdt_clear)
        repeat (4) @(posedge hclk);
        c_tbc = n_tbc;
        c_sub = n_sub;
        c_sys = n_sys;
        repeat (48) @(posedge hclk);
        `CHK("time base", idle, n_tbc != c_tbc)
        `CHK("substitute", 1'b1, n_sub != c_sub)
        `CHK("sys tick", idle & keep, n_sys != c_sys)
        rd(`CPM_ADDR_STATUS, r);
        `CHK("status", 32'h2, r)
        rd(`CPM_ADDR_CLK_MODE, r);
        `CHK("fast ready", idle & keep, r[2])
        pulse(EV_WAKE);
        @(posedge hclk);
        `CHK("cpu run", 1'b1, cpu_run)
    endtask

    task automatic t_flags;
        logic [31:0] r;
        int c;
        pulse(EV_LVR);
        pulse(EV_KEY);
        c = n_soft;
        wr(`CPM_ADDR_VTHR, 8'h12);
        repeat (4) @(posedge hclk);
        `CHK("soft reset", 1, n_soft - c)
        rd(`CPM_ADDR_SYS_CTRL, r);
        `CHK("flags", 32'h87, r)
        wr(`CPM_ADDR_VTHR, `CPM_VTHR_CODE2);
        wr(`CPM_ADDR_SYS_CTRL, 8'h07);
        rd(`CPM_ADDR_SYS_CTRL, r);
        `CHK("flags", 32'h07, r)
        wr(`CPM_ADDR_SYS_CTRL, 8'h00);
        rd(`CPM_ADDR_SYS_CTRL, r);
        `CHK("flags", 32'h00, r)
    endtask

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, slow_go, fast_osc_clk, slow_osc_clk} = 5'h00;
        {halt_instr, wake_event, clr_wdt_instr, wdt_timeout, lvr_event, wdt_key_bad} = 6'h00;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        slow_cnt = 4'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_ready();
        t_div();
        t_low(1'b0, 1'b0);
        t_low(1'b1, 1'b0);
        t_low(1'b1, 1'b1);
        t_flags();
        conclude();
    end
endmodule

`default_nettype wire
